/* chg_i2c_slave.sv */
// I2C target front end: byte framing, address match, register pointer
`timescale 1ns/1ps
`default_nettype none
`include "chg_regs.svh"
module chg_i2c_slave (
   input wire logic sys_clk,
   input wire logic rstn,
   input wire logic scl_in,
   input wire logic sda_in,
   output logic sda_oe,
   output logic [7:0] reg_addr,
   output logic [7:0] wr_data,
   output logic wr_stb,
   output logic rd_stb,
   input wire logic [7:0] rd_data,
   input wire logic addr_ok
);
   typedef enum logic [2:0] {ST_IDLE, ST_DEVADDR, ST_REGADDR, ST_WDATA, ST_RDATA, ST_ACK, ST_RACK} chg_i2c_st_t;
   chg_i2c_st_t st_q;
   chg_i2c_st_t nxt_q;
   logic scl_q, sda_q;
   logic [3:0] cnt_q;
   logic [7:0] sh_q;
   logic rw_q, ack_q, oe_q, ptr_done_q;
   logic [7:0] addr_q, wdat_q, tx_q;
   logic wr_q, rd_q;
   wire scl_rise = scl_in & ~scl_q;
   wire scl_fall = ~scl_in & scl_q;
   wire start_c = scl_in & scl_q & sda_q & ~sda_in;
   wire stop_c = scl_in & scl_q & ~sda_q & sda_in;
   wire [7:0] byte_w = {sh_q[6:0], sda_in};
   // Answer for the byte just framed: a refused byte leaves SDA released
   wire ack_now = (st_q == ST_DEVADDR) ? (sh_q[7:1] == `CHG_I2C_ADDR) : ((st_q == ST_REGADDR) | addr_ok);
   assign sda_oe = oe_q;
   assign reg_addr = addr_q;
   assign wr_data = wdat_q;
   assign wr_stb = wr_q;
   assign rd_stb = rd_q;
   // Bus sampling and byte engine; a data byte written to an undefined register gets NACK and idles
   always_ff @(posedge sys_clk) begin
      scl_q <= scl_in;
      sda_q <= sda_in;
      wr_q <= 1'b0;
      rd_q <= 1'b0;
      if (!rstn) begin
         st_q <= ST_IDLE;
         nxt_q <= ST_IDLE;
         cnt_q <= 4'h0;
         sh_q <= 8'h00;
         rw_q <= 1'b0;
         ack_q <= 1'b0;
         oe_q <= 1'b0;
         ptr_done_q <= 1'b0;
         addr_q <= 8'h00;
         wdat_q <= 8'h00;
         tx_q <= 8'h00;
         scl_q <= 1'b1;
         sda_q <= 1'b1;
      end else if (start_c) begin
         st_q <= ST_DEVADDR;
         cnt_q <= 4'h0;
         oe_q <= 1'b0;
      end else if (stop_c) begin
         st_q <= ST_IDLE;
         oe_q <= 1'b0;
      end else if (st_q != ST_IDLE) begin
         if (scl_rise && st_q != ST_ACK && st_q != ST_RDATA) begin
            sh_q <= byte_w;
            cnt_q <= cnt_q + 4'h1;
            if (st_q == ST_RACK && sda_in) begin
               st_q <= ST_IDLE; // Master NACK ends a read
            end
         end
         if (scl_rise && st_q == ST_RDATA) begin
            cnt_q <= cnt_q + 4'h1;
         end
         if (scl_fall) begin
            unique case (st_q)
               ST_DEVADDR, ST_REGADDR, ST_WDATA: begin
                  if (cnt_q == 4'h8) begin
                     cnt_q <= 4'h0;
                     ack_q <= 1'b0;
                     if (st_q == ST_DEVADDR) begin
                        rw_q <= sh_q[0];
                        ack_q <= (sh_q[7:1] == `CHG_I2C_ADDR);
                        nxt_q <= sh_q[0] ? ST_RDATA : ST_REGADDR;
                        if (sh_q[0]) begin
                           tx_q <= rd_data;
                           rd_q <= (sh_q[7:1] == `CHG_I2C_ADDR);
                        end
                     end else if (st_q == ST_REGADDR) begin
                        addr_q <= sh_q;
                        nxt_q <= ST_WDATA;
                        ack_q <= 1'b1;
                     end else begin
                        wdat_q <= sh_q;
                        wr_q <= addr_ok;
                        ack_q <= addr_ok;
                        nxt_q <= ST_WDATA;
                     end
                     st_q <= ST_ACK;
                     oe_q <= ack_now; // NACK keeps SDA high
                  end
               end
               ST_ACK: begin
                  // Drop ack; pointer advances after each written byte
                  oe_q <= 1'b0;
                  if (!ack_q) begin
                     st_q <= ST_IDLE;
                  end else begin
                     st_q <= nxt_q;
                     if (nxt_q == ST_RDATA) begin
                        oe_q <= ~tx_q[7];
                     end
                  end
                  if (nxt_q == ST_WDATA && ptr_done_q) begin
                     addr_q <= addr_q + 8'h01;
                  end
                  ptr_done_q <= (nxt_q == ST_WDATA) & ack_q;
               end
               ST_RDATA: begin
                  if (cnt_q == 4'h8) begin
                     oe_q <= 1'b0;
                     cnt_q <= 4'h0;
                     st_q <= ST_RACK;
                  end else begin
                     oe_q <= ~tx_q[3'd7 - cnt_q[2:0]];
                  end
               end
               ST_RACK: begin
                  addr_q <= addr_q + 8'h01;
                  rd_q <= 1'b1;
                  st_q <= ST_RDATA;
                  cnt_q <= 4'h0;
                  tx_q <= rd_data;
                  oe_q <= ~rd_data[7];
               end
               default: st_q <= ST_IDLE;
            endcase
         end
      end
   end
endmodule
`default_nettype wire

/* chg_regs.svh */
// Register offsets, field positions, reset values and encodings of the charger configuration bank
`ifndef CHG_REGS_SVH
`define CHG_REGS_SVH
`define CHG_I2C_ADDR 7'h6b
`define CHG_OFS_PWR_CFG 8'h01
`define CHG_OFS_CUR_CTL 8'h02
`define CHG_PWR_CFG_RST 8'h1b
`define CHG_CUR_CTL_RST 8'h60
`define CHG_BIT_REG_RESET 7
`define CHG_BIT_WDOG_RESTART 6
`define CHG_MODE_HI 5
`define CHG_MODE_LO 4
`define CHG_SYSMIN_HI 3
`define CHG_SYSMIN_LO 1
`define CHG_BIT_PWR_RSVD 0
`define CHG_FAST_CHARGE_CURRENT_HI 7
`define CHG_FAST_CHARGE_CURRENT_LO 2
`define CHG_BIT_CUR_RSVD 1
`define CHG_BIT_FORCE 0
`define CHG_SYSMIN_BASE_MV 12'd3000
`define CHG_SYSMIN_STEP_MV 12'd100
`define CHG_FAST_CHARGE_CURRENT_BASE_MA 13'd512
`define CHG_FAST_CHARGE_CURRENT_STEP_MA 13'd64
`define CHG_FAST_CHARGE_CURRENT_MAX_HI_MA 13'd4544
`define CHG_FAST_CHARGE_CURRENT_MAX_LO_MA 13'd2496
`define CHG_IPRE_BASE_MA 12'd128
`define CHG_IPRE_STEP_MA 12'd128
`endif

/* chg_pkg.sv */
// Types shared by the charger configuration bank
package chg_pkg;
   typedef enum logic [1:0] {
      CHG_MODE_OFF,
      CHG_MODE_CHARGE,
      CHG_MODE_BOOST
   } chg_mode_t;
endpackage

/* chg_cfg_regs.sv */
// Power-on configuration and charge current registers of the charger, reached over I2C
// Operation
// RULE1: Bit 7 write 1 restores defaults, self-clears
// RULE2: Bit 6 write 1 restarts watchdog, self-clears
// RULE3: Mode 00 off, 01 charge, 1x boost
// RULE4: System minimum 3.0 V plus 0.1 V steps
// RULE5: Host writes 1 to bit 0
// RULE6: Power-on register resets to 0x1b
// RULE7: Fast charge 512 mA plus 64 mA steps
// RULE8: Current capped at 4544 or 2496 mA
// RULE9: Host writes 0 to current bit 1
// RULE10: Force bit gives 20% and 50%
// RULE11: Current register resets to 0x60
// RULE12: Host restarts watchdog twice per period
// RULE13: Both registers at I2C address 0x6b
// RULE14: Self-clearing bits pulse once, read zero
`timescale 1ns/1ps
`default_nettype none
`include "chg_regs.svh"
module chg_cfg_regs (
   input wire logic sys_clk,
   input wire logic rstn,
   input wire logic scl_in,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe,
   input wire logic high_current_variant,
   input wire logic [3:0] precharge_current_limit,
   output chg_pkg::chg_mode_t charger_mode_select,
   output logic [2:0] minimum_system_voltage,
   output logic [11:0] minimum_system_voltage_mv,
   output logic [12:0] fast_charge_current_ma,
   output logic [11:0] precharge_current_ma,
   output logic force_reduced_current,
   output logic watchdog_restart,
   output logic regs_reset
);
   logic [7:0] pwr_cfg_q;
   logic [7:0] cur_ctl_q;
   logic [12:0] fast_charge_current_ma_q;
   logic [11:0] ipre_ma_q;
   logic [11:0] sysmin_mv_q;
   logic wd_q, rr_q;
   logic [7:0] reg_addr, wr_data, rd_data;
   logic wr_stb, rd_stb;
   // Decode of the two mapped registers
   wire sel_pwr = (reg_addr == `CHG_OFS_PWR_CFG);
   wire sel_cur = (reg_addr == `CHG_OFS_CUR_CTL);
   wire addr_ok = sel_pwr | sel_cur;
   wire wr_pwr = wr_stb & sel_pwr;
   wire wr_cur = wr_stb & sel_cur;
   wire do_reset = wr_pwr & wr_data[`CHG_BIT_REG_RESET]; // [RULE1]
   wire do_wdog = wr_pwr & wr_data[`CHG_BIT_WDOG_RESTART]; // [RULE2]
   // Self-clearing bits never read back as 1
   assign rd_data = sel_pwr ? {2'b00, pwr_cfg_q[5:0]} : (sel_cur ? cur_ctl_q : 8'h00); // [RULE14]
   chg_i2c_slave u_i2c (
      .sys_clk(sys_clk),
      .rstn(rstn),
      .scl_in(scl_in),
      .sda_in(sda_in),
      .sda_oe(sda_oe),
      .reg_addr(reg_addr),
      .wr_data(wr_data),
      .wr_stb(wr_stb),
      .rd_stb(rd_stb),
      .rd_data(rd_data),
      .addr_ok(addr_ok)
   ); // [RULE13]
   assign sda_out = 1'b0;
   // Register storage; a register-reset write wins over the data written
   always_ff @(posedge sys_clk) begin
      if (!rstn || do_reset) begin
         pwr_cfg_q <= `CHG_PWR_CFG_RST; // [RULE1] [RULE6]
         cur_ctl_q <= `CHG_CUR_CTL_RST; // [RULE11]
      end else begin
         if (wr_pwr) begin
            pwr_cfg_q <= {2'b00, wr_data[5:0]}; // [RULE5]
         end
         if (wr_cur) begin
            cur_ctl_q <= wr_data; // [RULE9]
         end
      end
   end
   // One-cycle action pulses per write of 1
   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         wd_q <= 1'b0;
         rr_q <= 1'b0;
      end else begin
         wd_q <= do_wdog; // [RULE2] [RULE14]
         rr_q <= do_reset; // [RULE14]
      end
   end
   assign watchdog_restart = wd_q;
   assign regs_reset = rr_q;
   // Mode decode: both upper codes select boost
   assign charger_mode_select = pwr_cfg_q[`CHG_MODE_HI] ? chg_pkg::CHG_MODE_BOOST :
      (pwr_cfg_q[`CHG_MODE_LO] ? chg_pkg::CHG_MODE_CHARGE : chg_pkg::CHG_MODE_OFF); // [RULE3]
   assign minimum_system_voltage = pwr_cfg_q[`CHG_SYSMIN_HI:`CHG_SYSMIN_LO];
   assign force_reduced_current = cur_ctl_q[`CHG_BIT_FORCE];
   // Applied current and voltage values
   wire [12:0] fast_charge_current_prog = `CHG_FAST_CHARGE_CURRENT_BASE_MA + 13'(cur_ctl_q[`CHG_FAST_CHARGE_CURRENT_HI:`CHG_FAST_CHARGE_CURRENT_LO]) * `CHG_FAST_CHARGE_CURRENT_STEP_MA; // [RULE7]
   wire [12:0] fast_charge_current_max = high_current_variant ? `CHG_FAST_CHARGE_CURRENT_MAX_HI_MA : `CHG_FAST_CHARGE_CURRENT_MAX_LO_MA;
   wire [12:0] fast_charge_current_cap = (fast_charge_current_prog > fast_charge_current_max) ? fast_charge_current_max : fast_charge_current_prog; // [RULE8]
   wire [15:0] fast_charge_current_20 = (16'(fast_charge_current_cap) * 16'd2) / 16'd10;
   wire [11:0] ipre_prog = `CHG_IPRE_BASE_MA + 12'(precharge_current_limit) * `CHG_IPRE_STEP_MA;
   wire [11:0] sysmin = `CHG_SYSMIN_BASE_MV + 12'(minimum_system_voltage) * `CHG_SYSMIN_STEP_MV; // [RULE4]
   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         fast_charge_current_ma_q <= 13'd0;
         ipre_ma_q <= 12'd0;
         sysmin_mv_q <= 12'd0;
      end else begin
         fast_charge_current_ma_q <= force_reduced_current ? fast_charge_current_20[12:0] : fast_charge_current_cap; // [RULE10]
         ipre_ma_q <= force_reduced_current ? {1'b0, ipre_prog[11:1]} : ipre_prog; // [RULE10]
         sysmin_mv_q <= sysmin;
      end
   end
   assign fast_charge_current_ma = fast_charge_current_ma_q;
   assign precharge_current_ma = ipre_ma_q;
   assign minimum_system_voltage_mv = sysmin_mv_q;
endmodule
`default_nettype wire

/* chg_cfg_sva.sv */
// Concurrent checks on the charger configuration bank ports
`timescale 1ns/1ps
`default_nettype none
module chg_cfg_sva (
   input wire logic sys_clk,
   input wire logic rstn,
   input wire logic sda_oe,
   input wire logic high_current_variant,
   input wire logic [3:0] precharge_current_limit,
   input wire chg_pkg::chg_mode_t charger_mode_select,
   input wire logic [2:0] minimum_system_voltage,
   input wire logic [11:0] minimum_system_voltage_mv,
   input wire logic [12:0] fast_charge_current_ma,
   input wire logic [11:0] precharge_current_ma,
   input wire logic force_reduced_current,
   input wire logic watchdog_restart,
   input wire logic regs_reset
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!rstn);
   // Decoded fields and derived settings
   mode_legal_a: assert property (charger_mode_select != 2'h3) else $error("mode out of range");
   sysmin_mv_a: assert property ($past(rstn) && $stable(minimum_system_voltage) |->
      minimum_system_voltage_mv == 12'd3000 + 12'd100 * minimum_system_voltage) else $error("system minimum wrong");
   current_cap_a: assert property ($past(rstn) && $stable(high_current_variant) |->
      fast_charge_current_ma <= (high_current_variant ? 13'd4544 : 13'd2496)) else $error("current over cap");
   fast_step_a: assert property ($past(rstn) && !force_reduced_current && $stable(force_reduced_current) |->
      fast_charge_current_ma[5:0] == 6'h00 && fast_charge_current_ma >= 13'd512) else $error("fast step wrong");
   precharge_half_a: assert property ($past(rstn) && $stable(force_reduced_current) &&
      $stable(precharge_current_limit) |->
      precharge_current_ma == (12'd128 + 12'd128 * precharge_current_limit) >> force_reduced_current)
      else $error("precharge wrong");
   // Self-clearing actions and reset state
   reset_pulse_a: assert property (regs_reset |=> !regs_reset) else $error("reset pulse long");
   restart_pulse_a: assert property (watchdog_restart |=> !watchdog_restart) else $error("restart long");
   defaults_back_a: assert property (regs_reset |-> ##[0:2] (minimum_system_voltage == 3'h5 &&
      charger_mode_select == chg_pkg::CHG_MODE_CHARGE && !force_reduced_current)) else $error("no defaults");
   reset_state_a: assert property (disable iff (1'b0) !rstn |=> !regs_reset && !watchdog_restart &&
      !sda_oe && !force_reduced_current && minimum_system_voltage == 3'h5) else $error("reset state wrong");
   cover property (regs_reset);
   cover property (watchdog_restart);
   cover property (force_reduced_current && !high_current_variant);
endmodule
`default_nettype wire

/* chg_i2c_host.sv */
// Behavioural I2C bus master standing in for the host processor
`timescale 1ns/1ps
`default_nettype none
`include "chg_regs.svh"
module chg_i2c_host (
   input wire logic sys_clk,
   input wire logic sda,
   output logic scl,
   output logic sda_oe
);
   logic [8:0] r;
   logic nak;
   initial begin
      scl = 1'b1;
      sda_oe = 1'b0;
   end
   // Quarter bit; lines change just after a falling clock edge
   task automatic ph(input logic c, input logic d);
      scl = c;
      sda_oe = !d;
      repeat (4) @(negedge sys_clk);
   endtask
   // Nine bits MSB first, data moves only while SCL is low
   task automatic xfer(input logic [8:0] tx);
      for (int i = 8; i >= 0; i--) begin
         ph(1'b0, tx[i]);
         ph(1'b1, tx[i]);
         r[i] = sda;
         ph(1'b1, tx[i]);
         ph(1'b0, tx[i]);
      end
   endtask
   task automatic sta();
      ph(1'b0, 1'b1);
      ph(1'b1, 1'b1);
      ph(1'b1, 1'b0);
      ph(1'b0, 1'b0);
   endtask
   task automatic sto();
      ph(1'b0, 1'b0);
      ph(1'b1, 1'b0);
      ph(1'b1, 1'b1);
   endtask
   // Register write; nak gathers any refused byte
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      sta();
      xfer({`CHG_I2C_ADDR, 1'b0, 1'b1});
      nak = r[0];
      xfer({a, 1'b1});
      nak |= r[0];
      xfer({d, 1'b1});
      nak |= r[0];
      sto();
   endtask
   // Pointer write, repeated start, one byte read ended by NACK
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      sta();
      xfer({`CHG_I2C_ADDR, 1'b0, 1'b1});
      xfer({a, 1'b1});
      sta();
      xfer({`CHG_I2C_ADDR, 1'b1, 1'b1});
      xfer(9'h1ff);
      d = r[8:1];
      sto();
   endtask
endmodule
`default_nettype wire

/* tb_top.sv */
// Self-checking bench for the charger configuration bank
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   logic sys_clk, rstn, hcv;
   logic [3:0] pre;
   logic [7:0] v;
   chg_pkg::chg_mode_t mode;
   wire logic scl, h_oe, d_oe, frc, wdr, rrs;
   wire logic sda = !(h_oe || d_oe);
   wire logic [2:0] smv;
   wire logic [11:0] smm, pmv;
   wire logic [12:0] fcm;
   int mismatches = 0, comparisons = 0, cyc = 0, wd_n = 0, rr_n = 0;
   chg_cfg_regs dut (.sys_clk(sys_clk), .rstn(rstn), .scl_in(scl), .sda_in(sda), .sda_out(), .sda_oe(d_oe),
      .high_current_variant(hcv), .precharge_current_limit(pre), .charger_mode_select(mode),
      .minimum_system_voltage(smv), .minimum_system_voltage_mv(smm), .fast_charge_current_ma(fcm), .precharge_current_ma(pmv),
      .force_reduced_current(frc), .watchdog_restart(wdr), .regs_reset(rrs));
   chg_i2c_host host (.sys_clk(sys_clk), .sda(sda), .scl(scl), .sda_oe(h_oe));
   initial begin
      sys_clk = 1'b0;
      forever #2.5 sys_clk = !sys_clk;
   end
   // Pulse counters and hang guard
   always @(posedge sys_clk) begin
      cyc++;
      if (wdr === 1'b1) wd_n++;
      if (rrs === 1'b1) rr_n++;
      if (cyc == 60000) begin
         mismatches++;
         end_of_test();
      end
   end
   task automatic chk(input string n, input logic [15:0] e, input logic [15:0] s);
      comparisons++;
      if (s !== e) begin
         mismatches++;
         $display("Error %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic rchk(input logic [7:0] a, input logic [7:0] e);
      host.rd(a, v);
      chk("register", {8'h00, e}, {8'h00, v});
   endtask
   task automatic end_of_test();
      $display("mismatches %0d comparisons %0d", mismatches, comparisons);
      if (mismatches == 0 && comparisons > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   initial begin
      rstn = 1'b0;
      hcv = 1'b1;
      pre = 4'h1;
      repeat (16) @(negedge sys_clk);
      rstn = 1'b1;
      @(negedge sys_clk);
      rchk(8'h01, 8'h1b);
      rchk(8'h02, 8'h60);
      // Every mode code and every system minimum code
      for (int i = 0; i < 8; i++) begin
         host.wr(8'h01, {2'b00, i[1:0], i[2:0], 1'b1});
         rchk(8'h01, {2'b00, i[1:0], i[2:0], 1'b1});
         chk("mode", (i[1:0] == 2'h0) ? 16'h0 : (i[1:0] == 2'h1) ? 16'h1 : 16'h2, mode);
         chk("sysmin", 16'd3000 + 16'd100 * i[2:0], smm);
      end
      host.wr(8'h02, 8'h64);
      chk("ack", 16'h0, {15'h0, host.nak});
      chk("fast", 16'd2112, fcm);
      host.wr(8'h02, 8'hfc);
      chk("cap_hi", 16'd4544, fcm);
      hcv = 1'b0;
      repeat (2) @(negedge sys_clk);
      chk("cap_lo", 16'd2496, fcm);
      chk("pre", 16'd256, pmv);
      host.wr(8'h02, 8'h09);
      chk("fast_force", 16'd128, fcm);
      chk("pre_force", 16'd128, pmv);
      host.wr(8'h01, 8'h5b);
      host.wr(8'h01, 8'h5b);
      chk("restarts", 16'd2, wd_n[15:0]);
      rchk(8'h01, 8'h1b);
      host.wr(8'h01, 8'h2f);
      host.wr(8'h01, 8'hab);
      chk("resets", 16'd1, rr_n[15:0]);
      rchk(8'h01, 8'h1b);
      rchk(8'h02, 8'h60);
      host.wr(8'h05, 8'h00);
      chk("nak", 16'h1, {15'h0, host.nak});
      end_of_test();
   end
endmodule
bind chg_cfg_regs chg_cfg_sva chk_i (.sys_clk, .rstn, .sda_oe, .high_current_variant, .precharge_current_limit,
   .charger_mode_select, .minimum_system_voltage, .minimum_system_voltage_mv, .fast_charge_current_ma, .precharge_current_ma,
   .force_reduced_current, .watchdog_restart, .regs_reset);
`default_nettype wire
